// ==== rtl/incdec_branch_exec.sv ====
// Execution unit for skip, increment, OR and branch instructions.
`timescale 1ns/100ps
module incdec_branch_exec (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Decoded instruction, one per instruction cycle.
    input wire logic instr_valid,
    input wire incdec_branch_pkg::instr_t instr,
    // File register read data for the addressed register.
    input wire logic [incdec_branch_pkg::DATA_W-1:0] file_rdata,
    // Upper address latch contents.
    input wire logic [incdec_branch_pkg::LATCH_W-1:0] upper_address_latch,
    // File register write port and registered read address.
    output incdec_branch_pkg::file_wr_t file_wr,
    output logic [incdec_branch_pkg::FADDR_W-1:0] file_raddr,
    // Architectural results.
    output logic [incdec_branch_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic [incdec_branch_pkg::PC_W-1:0] program_counter,
    output logic pc_load,
    output logic squash_next,
    output logic busy
);
    import incdec_branch_pkg::*;

    // Every check below runs on the system clock and is muted in reset.
    default clocking sys_edge @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FLUSH = 2'b01
    } state_t;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == ZERO);
    endfunction

    state_t state_ff;
    logic [DATA_W-1:0] acc_ff;
    logic zero_ff;
    logic [PC_W-1:0] pc_ff;
    logic pc_load_ff;
    logic squash_ff;
    logic busy_ff;
    file_wr_t wr_ff;
    logic [FADDR_W-1:0] raddr_ff;
    logic [DATA_W-1:0] nxt_result;
    logic nxt_flag_en;
    logic nxt_skip;
    logic nxt_writes;
    logic take;

    // An instruction in the flush cycle is the squashed slot and does nothing.
    assign take = instr_valid && (state_ff == ST_RUN);

    always_comb begin
        nxt_result = ZERO;
        nxt_flag_en = 1'b0;
        nxt_skip = 1'b0;
        nxt_writes = 1'b0;
        case (instr.op)
            OP_DEC_SKIP: begin
                nxt_result = file_rdata - ONE;
                nxt_skip = is_zero(nxt_result);
                nxt_writes = 1'b1;
            end
            OP_INC_SKIP: begin
                nxt_result = file_rdata + ONE;
                nxt_skip = is_zero(nxt_result);
                nxt_writes = 1'b1;
            end
            OP_INC: begin
                nxt_result = file_rdata + ONE;
                nxt_flag_en = 1'b1;
                nxt_writes = 1'b1;
            end
            OP_OR_REG: begin
                nxt_result = acc_ff | file_rdata;
                nxt_flag_en = 1'b1;
                nxt_writes = 1'b1;
            end
            OP_OR_LIT: begin
                nxt_result = acc_ff | instr.imm[DATA_W-1:0];
                nxt_flag_en = 1'b1;
            end
            default: begin
                nxt_result = ZERO;
            end
        endcase
    end

    // The read address follows the decoded operand combinationally upstream;
    // it is registered here only to keep every output on a flip-flop.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            raddr_ff <= '0;
        end else begin
            raddr_ff <= instr.faddr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc_ff <= ACC_RESET;
        end else if (take && instr.op == OP_OR_LIT) begin
            acc_ff <= nxt_result;
        end else if (take && nxt_writes && instr.dest == DEST_ACC) begin
            acc_ff <= nxt_result;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_ff <= '0;
        end else begin
            wr_ff.we <= take && nxt_writes && instr.dest == DEST_FILE;
            wr_ff.addr <= instr.faddr;
            wr_ff.data <= nxt_result;
        end
    end

    // Skips and branches leave the flag alone; only flag-setting ops update.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            zero_ff <= 1'b0;
        end else if (take && nxt_flag_en) begin
            zero_ff <= is_zero(nxt_result);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pc_ff <= PC_RESET;
            pc_load_ff <= 1'b0;
        end else if (take && instr.op == OP_BRANCH) begin
            pc_ff <= {upper_address_latch[LATCH_HI:LATCH_LO], instr.imm};
            pc_load_ff <= 1'b1;
        end else begin
            pc_load_ff <= 1'b0;
        end
    end

    // Skips with a zero result and all branches spend one extra cycle flushing the next slot.
    // Busy has its own flop so that the output never passes through a decode.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= ST_RUN;
            squash_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (take && (nxt_skip || instr.op == OP_BRANCH)) begin
                        state_ff <= ST_FLUSH;
                        squash_ff <= 1'b1;
                        busy_ff <= 1'b1;
                    end else begin
                        squash_ff <= 1'b0;
                        busy_ff <= 1'b0;
                    end
                end
                ST_FLUSH: begin
                    state_ff <= ST_RUN;
                    squash_ff <= 1'b0;
                    busy_ff <= 1'b0;
                end
                default: begin
                    state_ff <= ST_RUN;
                    squash_ff <= 1'b0;
                    busy_ff <= 1'b0;
                end
            endcase
        end
    end

    assign acc = acc_ff;
    assign zero_flag = zero_ff;
    assign program_counter = pc_ff;
    assign pc_load = pc_load_ff;
    assign squash_next = squash_ff;
    assign busy = busy_ff;
    assign file_wr = wr_ff;
    assign file_raddr = raddr_ff;

    sequence s_branch;
        instr_valid && state_ff == ST_RUN && instr.op == OP_BRANCH;
    endsequence

    sequence s_zero_skip;
        instr_valid && state_ff == ST_RUN && nxt_skip;
    endsequence

    // One squashed slot, then back to normal issue.
    sequence s_one_slot_flush;
        squash_next && busy ##1 !squash_next && !busy;
    endsequence

    a_dec_result: assert property (
        take && instr.op == OP_DEC_SKIP |=>
        file_wr.data == $past(file_rdata) - ONE)
        else $error("decrement result wrong");

    a_dec_flags: assert property (
        take && instr.op == OP_DEC_SKIP |=> $stable(zero_flag))
        else $error("decrement skip touched flag");

    a_dest_select: assert property (
        take && nxt_writes && instr.dest == DEST_FILE |=>
        file_wr.we && file_wr.addr == $past(instr.faddr))
        else $error("file destination not written");

    a_acc_dest: assert property (
        take && instr.op == OP_INC && instr.dest == DEST_ACC |=>
        acc == $past(file_rdata) + ONE && !file_wr.we)
        else $error("accumulator destination wrong");

    a_read_addr: assert property (
        instr_valid |=> file_raddr == $past(instr.faddr))
        else $error("read address not tracked");

    a_dec_skip: assert property (
        take && instr.op == OP_DEC_SKIP && file_rdata == ONE |=>
        s_one_slot_flush)
        else $error("decrement skip missing");

    // A slot offered during the flush must not write, load the PC, squash, or change acc or the flag.
    a_slot_refused: assert property (
        instr_valid && busy |=>
        !file_wr.we && !pc_load && !squash_next && $stable(acc)
        && $stable(zero_flag))
        else $error("flushed slot executed");

    a_inc_skip: assert property (
        take && instr.op == OP_INC_SKIP && file_rdata != 8'hFF |=>
        !squash_next)
        else $error("increment skip spurious");

    a_inc_skip_zero: assert property (
        take && instr.op == OP_INC_SKIP && file_rdata == 8'hFF |=>
        s_one_slot_flush)
        else $error("increment skip missing");

    a_skip_flags: assert property (
        take && instr.op == OP_INC_SKIP |=>
        $stable(zero_flag))
        else $error("increment skip touched flag");

    a_inc_skip_sum: assert property (
        take && instr.op == OP_INC_SKIP |=>
        file_wr.data == $past(file_rdata) + ONE)
        else $error("increment skip result wrong");

    a_branch_target: assert property (
        s_branch |=> pc_load && program_counter ==
        {$past(upper_address_latch[LATCH_HI:LATCH_LO]), $past(instr.imm)})
        else $error("branch target wrong");

    a_pc_hold: assert property (
        !(take && instr.op == OP_BRANCH) |=>
        !pc_load && $stable(program_counter))
        else $error("program counter moved without branch");

    a_branch_cycles: assert property (
        s_branch |=> busy && $stable(zero_flag) ##1 !busy)
        else $error("branch timing wrong");

    a_branch_quiet: assert property (
        s_branch |=> !file_wr.we && $stable(acc))
        else $error("branch wrote data");

    a_or_literal: assert property (
        take && instr.op == OP_OR_LIT |=>
        acc == ($past(acc) | $past(instr.imm[DATA_W-1:0])))
        else $error("or literal wrong");

    a_or_literal_dest: assert property (
        take && instr.op == OP_OR_LIT |=> !file_wr.we)
        else $error("or literal wrote file");

    a_inc_zero: assert property (
        take && instr.op == OP_INC |=>
        zero_flag == ($past(file_rdata) == 8'hFF) && !squash_next)
        else $error("increment zero flag wrong");

    a_or_register: assert property (
        take && instr.op == OP_OR_REG |=>
        zero_flag == (($past(acc) | $past(file_rdata)) == ZERO))
        else $error("or register flag wrong");

    a_or_register_data: assert property (
        take && instr.op == OP_OR_REG && instr.dest == DEST_FILE |=>
        file_wr.data == ($past(acc) | $past(file_rdata)))
        else $error("or register data wrong");

    a_zero_skip_flush: assert property (
        s_zero_skip |=> busy)
        else $error("skip without flush");

    // Wrap-around is the one case where a lost carry would go unseen.
    a_inc_wrap: assert property (
        take && instr.op == OP_INC && file_rdata == 8'hFF |=>
        file_wr.data == ZERO && zero_flag)
        else $error("increment wrap wrong");
endmodule

// ==== rtl/incdec_branch_pkg.sv ====
// Constants and carrier types for the skip, increment, OR and branch unit.
package incdec_branch_pkg;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int TARGET_W = 11;
    localparam int PC_W = 13;
    localparam int LATCH_W = 8;
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 4;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [7:0] ZERO = 8'h00;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_DEC_SKIP = 3'h1,
        OP_INC_SKIP = 3'h2,
        OP_BRANCH = 3'h3,
        OP_OR_LIT = 3'h4,
        OP_INC = 3'h5,
        OP_OR_REG = 3'h6
    } op_t;

    typedef struct packed {
        op_t op;
        logic [FADDR_W-1:0] faddr;
        logic dest;
        logic [TARGET_W-1:0] imm;
    } instr_t;

    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } file_wr_t;
endpackage

// ==== tb/file_regs_model.sv ====
// Behavioural data register file that faces the execution unit.
`timescale 1ns/100ps
module file_regs_model (
    // Clock.
    input wire logic clk_sys,
    // Read and write sides.
    input wire logic [incdec_branch_pkg::FADDR_W-1:0] raddr,
    output logic [incdec_branch_pkg::DATA_W-1:0] rdata,
    input wire incdec_branch_pkg::file_wr_t wr
);
    import incdec_branch_pkg::*;
    logic [DATA_W-1:0] mem_ff [128];
    // The read is combinational, so the operand arrives in the same cycle.
    assign rdata = mem_ff[raddr];
    always @(posedge clk_sys) begin
        if (wr.we) begin
            mem_ff[wr.addr] <= wr.data;
        end
    end
endmodule

// ==== tb/incdec_branch_exec_tb.sv ====
// Self-checking bench for the skip, increment, OR and branch unit.
`timescale 1ns/100ps
module incdec_branch_exec_tb;
    import incdec_branch_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    instr_t instr = '0;
    logic [7:0] latch = 8'h00;
    logic [7:0] rdata;
    file_wr_t file_wr;
    logic [12:0] pc;
    logic [6:0] raddr;
    logic [7:0] acc;
    logic zero_flag, pc_load, squash_next, busy;
    logic [7:0] exp_acc = 8'h00;
    logic exp_z = 1'b0;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;

    incdec_branch_exec i_dut (.clk_sys(clk_sys), .reset(reset),
        .instr_valid(instr_valid), .instr(instr), .file_rdata(rdata),
        .upper_address_latch(latch), .file_wr(file_wr), .file_raddr(raddr),
        .acc(acc), .zero_flag(zero_flag), .program_counter(pc),
        .pc_load(pc_load), .squash_next(squash_next), .busy(busy));
    file_regs_model i_file (.clk_sys(clk_sys), .raddr(instr.faddr),
        .rdata(rdata), .wr(file_wr));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Issues one instruction and judges the cycle after it was taken.
    // With follow set, the same word is offered again in the flushed slot.
    task automatic run(input op_t op, input logic [6:0] fa, input logic d,
            input logic [10:0] imm, input logic [7:0] rd, input logic we,
            input logic [7:0] wd, input logic follow);
        logic sq;
        sq = (op == OP_BRANCH) ||
            ((op == OP_DEC_SKIP || op == OP_INC_SKIP) && wd == 8'h00);
        i_file.mem_ff[fa] = rd;
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr <= '{op, fa, d, imm};
        @(posedge clk_sys);
        instr_valid <= follow;
        #1;
        check("acc", acc, exp_acc);
        check("zero", zero_flag, exp_z);
        check("we", file_wr.we, we);
        check("raddr", raddr, fa);
        if (we) begin
            check("wdata", {file_wr.addr, file_wr.data}, {fa, wd});
        end
        check("squash", {squash_next, busy}, {sq, sq});
        check("pc_load", pc_load, op == OP_BRANCH);
        if (follow) begin
            @(posedge clk_sys);
            instr_valid <= 1'b0;
            #1;
            check("flushed", {file_wr.we, squash_next, busy, acc},
                {3'b000, exp_acc});
        end
    endtask

    task automatic t_or_literal();
        exp_z = 1'b1;
        run(OP_OR_LIT, 7'h01, DEST_FILE, 11'h000, 8'h00, 0, 0, 0);
        exp_acc = 8'h5a;
        exp_z = 1'b0;
        run(OP_OR_LIT, 7'h01, DEST_ACC, 11'h05a, 8'h00, 0, 0, 0);
        $display("or literal done");
    endtask

    task automatic t_inc();
        exp_acc = 8'h42;
        run(OP_INC, 7'h09, DEST_ACC, 11'h000, 8'h41, 0, 8'h42, 0);
        exp_z = 1'b1;
        run(OP_INC, 7'h0a, DEST_FILE, 11'h000, 8'hff, 1, 8'h00, 0);
        $display("increment done");
    endtask

    // The zero flag is 1 here, so a flag write by the skip with a nonzero result shows.
    task automatic t_dec_skip();
        run(OP_DEC_SKIP, 7'h05, DEST_FILE, 0, 8'h01, 1, 8'h00, 1);
        exp_acc = 8'h0f;
        run(OP_DEC_SKIP, 7'h7f, DEST_ACC, 0, 8'h10, 0, 8'h0f, 0);
        $display("decrement skip done");
    endtask

    task automatic t_inc_skip();
        exp_acc = 8'h00;
        run(OP_INC_SKIP, 7'h00, DEST_ACC, 0, 8'hff, 0, 8'h00, 1);
        run(OP_INC_SKIP, 7'h07, DEST_FILE, 0, 8'h03, 1, 8'h04, 0);
        $display("increment skip done");
    endtask

    task automatic t_branch();
        @(posedge clk_sys);
        latch <= 8'hf8;
        run(OP_BRANCH, 7'h00, DEST_ACC, 11'h7ff, 8'h00, 0, 0, 1);
        check("pc", pc, 13'h1fff);
        @(posedge clk_sys);
        latch <= 8'h0c;
        run(OP_BRANCH, 7'h00, DEST_ACC, 11'h400, 8'h00, 0, 0, 0);
        check("pc", pc, 13'h0c00);
        $display("branch done");
    endtask

    task automatic t_or_reg();
        exp_acc = 8'ha5;
        exp_z = 1'b0;
        run(OP_OR_REG, 7'h11, DEST_ACC, 0, 8'ha5, 0, 8'ha5, 0);
        run(OP_OR_REG, 7'h12, DEST_FILE, 0, 8'h0f, 1, 8'haf, 0);
        $display("or register done");
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 500) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        check("reset", {acc, zero_flag, pc, pc_load, squash_next, busy,
            file_wr.we}, 32'h0000_0000);
        t_or_literal();
        t_inc();
        t_dec_skip();
        t_inc_skip();
        t_branch();
        t_or_reg();
        tally_and_finish();
    end
endmodule
